/* core/lpct_pkg.sv */
// Contract
// - accept I/O write, I/O read, DMA write, DMA read, one byte each.
// - ignore unsupported cycle types and leave LAD undriven.
// - on sampling frame low, release LAD next clock and watch for START.
// - I/O target cycles carry at least one wait state.
// - DMA read brings a byte in, DMA write sends a byte out.
// - device requests DMA on the request pin; host answers with DMA codes.
// - keep working when powerdown asserts and releases without bus reset.
// - powerdown resets and holds only the bus block in reset.
// - while powerdown is seen asserted, float the DMA request pin.
// - once powerdown is seen released, drive the DMA request pin high.
// - on reads, drive SYNC as soon as the cycle is claimed.
// - wait with 0101 or 0110 until ready, then ready 0000 or error.
// - never switch between short and long wait codes within a cycle.
// - data follows the ready SYNC on the very next clock.
// - every DMA wait state uses the short-wait code 0101.
// - every I/O wait state uses the long-wait code 0110.
// - a valid SYNC appears within three clocks of the SYNC slot.
// - error SYNC 1010; reads still send two data nibbles; DMA ends.
// - I/O and DMA cycles start with START field 0000.
// - under bus reset ignore frame, float LAD, drive DMA request high.
// - waits: I/O read 3, I/O write 2, DMA read 3, DMA write 4.
package lpct_pkg;
  // LAD field codes
  localparam logic [3:0] START_CODE = 4'h0;
  localparam logic [3:0] CT_IO_RD = 4'h0;
  localparam logic [3:0] CT_IO_WR = 4'h2;
  localparam logic [3:0] CT_DMA_RD = 4'h8;
  localparam logic [3:0] CT_DMA_WR = 4'hA;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] SYNC_SHORT = 4'h5;
  localparam logic [3:0] SYNC_LONG = 4'h6;
  localparam logic [3:0] SYNC_ERR = 4'hA;
  localparam logic [3:0] TAR_CODE = 4'hF;
  localparam logic [1:0] SIZE_ONE_BYTE = 2'h0;
  // wait states per cycle kind
  localparam logic [2:0] WAIT_IO_RD = 3'h3;
  localparam logic [2:0] WAIT_IO_WR = 3'h2;
  localparam logic [2:0] WAIT_DMA_RD = 3'h3;
  localparam logic [2:0] WAIT_DMA_WR = 3'h4;
  localparam logic [2:0] WAIT_SAT = 3'h7;
  // dma request message: start bit, channel, active bit
  localparam logic [2:0] DMA_CHAN = 3'h2;
  localparam logic [2:0] LDRQ_BITS = 3'h5;
  // function address windows
  localparam int NUM_RANGES = 2;
  localparam logic [15:0] RANGE_BASE [NUM_RANGES] = '{16'h0300, 16'h0310};
  localparam logic [15:0] RANGE_LAST [NUM_RANGES] = '{16'h0307, 16'h0317};

  typedef enum logic [1:0] {
    KIND_IO_RD,
    KIND_IO_WR,
    KIND_DMA_RD,
    KIND_DMA_WR
  } lpct_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CTYPE,
    ST_ADDR,
    ST_CHAN,
    ST_SIZE,
    ST_WDATA,
    ST_TAR1,
    ST_TAR2,
    ST_SYNC,
    ST_READY,
    ST_RDATA,
    ST_TARB
  } lpct_state_t;
endpackage : lpct_pkg

/* core/lpct_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
// two-flop level synchroniser
module lpct_sync2 (
  // clock
  input wire logic clk,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    meta <= din;
    dout <= meta;
  end
endmodule : lpct_sync2
`default_nettype wire

/* core/lpct_target.sv */
`timescale 1ns/1ns
`default_nettype none
module lpct_target (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // link clock, resets and pins
  input wire logic link_clk,
  input wire logic host_bus_reset_n,
  input wire logic lpcpd_n,
  input wire logic lframe_n,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe,
  output logic ldrq_out,
  output logic ldrq_oe,
  // function request and answer
  output logic usr_req_valid,
  input wire logic usr_req_ready,
  output lpct_pkg::lpct_kind_t usr_req_kind,
  output logic [15:0] usr_req_addr,
  output logic [7:0] usr_req_wdata,
  input wire logic [7:0] usr_rsp_rdata,
  input wire logic usr_rsp_err,
  // function configuration and status
  input wire logic [lpct_pkg::NUM_RANGES-1:0] usr_range_en,
  input wire logic usr_dma_active,
  output logic usr_link_up
);
  import lpct_pkg::*;

  logic core_rst_s, hbr_s, pd_s, dma_act_s, ack_s, req_s, link_rst_n;
  logic [NUM_RANGES-1:0] range_en_s, range_hit;
  lpct_state_t state, next_state;
  lpct_kind_t kind, ct_kind;
  logic [15:0] addr, addr_shift;
  logic [7:0] wdata, rd_hold;
  logic [1:0] ncnt;
  logic [2:0] wcnt, wait_need, drq_cnt;
  logic [4:0] drq_bits;
  logic [3:0] next_lad;
  logic next_oe, issued, req_tgl, ack_tgl, req_seen, err_hold, drq_last;
  logic link_up_l, ct_ok, addr_hit, host_sends, is_dma, busy, issue;
  logic sync_done;

  // link-side synchronisers
  lpct_sync2 u_core_rst (.clk(link_clk), .din(reset_n), .dout(core_rst_s));
  lpct_sync2 u_hbr (.clk(link_clk), .din(host_bus_reset_n), .dout(hbr_s));
  lpct_sync2 u_pd (.clk(link_clk), .din(lpcpd_n), .dout(pd_s));
  lpct_sync2 u_dma (.clk(link_clk), .din(usr_dma_active), .dout(dma_act_s));
  lpct_sync2 u_ack (.clk(link_clk), .din(ack_tgl), .dout(ack_s));
  // system-side synchronisers
  lpct_sync2 u_req (.clk(sys_clk), .din(req_tgl), .dout(req_s));
  lpct_sync2 u_up (.clk(sys_clk), .din(link_up_l), .dout(usr_link_up));

  // window enables and match per function range
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RANGES; gi++)
    begin : g_range
      lpct_sync2 u_en (.clk(link_clk), .din(usr_range_en[gi]),
                       .dout(range_en_s[gi]));
      assign range_hit[gi] = range_en_s[gi] && addr_shift >= RANGE_BASE[gi]
                             && addr_shift <= RANGE_LAST[gi];
    end
  endgenerate

  // bus block reset: system, host bus reset or powerdown
  assign link_rst_n = core_rst_s & hbr_s & pd_s;
  assign addr_shift = {addr[11:0], lad_in};
  assign addr_hit = |range_hit;

  // cycle type decode, unknown types are dropped
  assign ct_ok = lad_in == CT_IO_RD || lad_in == CT_IO_WR ||
                 lad_in == CT_DMA_RD || lad_in == CT_DMA_WR;
  assign ct_kind = lad_in == CT_IO_WR ? KIND_IO_WR :
                   lad_in == CT_DMA_RD ? KIND_DMA_RD :
                   lad_in == CT_DMA_WR ? KIND_DMA_WR : KIND_IO_RD;

  // direction and wait budget of the current cycle
  assign host_sends = kind == KIND_IO_WR || kind == KIND_DMA_RD;
  assign is_dma = kind == KIND_DMA_RD || kind == KIND_DMA_WR;
  assign wait_need = kind == KIND_IO_RD ? WAIT_IO_RD :
                     kind == KIND_IO_WR ? WAIT_IO_WR :
                     kind == KIND_DMA_RD ? WAIT_DMA_RD : WAIT_DMA_WR;

  // function handshake state
  assign busy = req_tgl ^ ack_s;
  assign issue = state == ST_SYNC && !issued && !busy;
  assign sync_done = issued && !busy &&
                     wcnt >= 3'(wait_need - 3'h1);

  // cycle sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_CTYPE:
        next_state = !ct_ok ? ST_IDLE :
                     (ct_kind == KIND_DMA_RD || ct_kind == KIND_DMA_WR) ?
                     ST_CHAN : ST_ADDR;
      ST_ADDR:
        if (ncnt == 2'h3)
          next_state = !addr_hit ? ST_IDLE :
                       host_sends ? ST_WDATA : ST_TAR1;
      ST_CHAN:
        next_state = lad_in[2:0] == DMA_CHAN ? ST_SIZE : ST_IDLE;
      ST_SIZE:
        next_state = lad_in[1:0] != SIZE_ONE_BYTE ? ST_IDLE :
                     host_sends ? ST_WDATA : ST_TAR1;
      ST_WDATA: next_state = ncnt[0] ? ST_TAR1 : ST_WDATA;
      ST_TAR1: next_state = ST_TAR2;
      ST_TAR2: next_state = ST_SYNC;
      // no timeout here: waits last until the function answers
      ST_SYNC: next_state = sync_done ? ST_READY : ST_SYNC;
      ST_READY: next_state = host_sends ? ST_TARB : ST_RDATA;
      ST_RDATA: next_state = ncnt[0] ? ST_TARB : ST_RDATA;
      ST_TARB: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    // frame low restarts decode from any state
    if (!lframe_n)
      next_state = lad_in == START_CODE ? ST_CTYPE : ST_IDLE;
  end

  // what the device drives on LAD in the next cycle
  always_comb
  begin
    next_oe = 1'b1;
    next_lad = TAR_CODE;
    unique case (next_state)
      ST_SYNC: next_lad = is_dma ? SYNC_SHORT : SYNC_LONG;
      ST_READY: next_lad = err_hold ? SYNC_ERR : SYNC_READY;
      ST_RDATA: next_lad = state == ST_RDATA ? rd_hold[7:4] : rd_hold[3:0];
      ST_TARB: next_lad = TAR_CODE;
      default: next_oe = 1'b0;
    endcase
  end

  // state and pin registers
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      state <= ST_IDLE;
      lad_oe <= 1'b0;
      lad_out <= TAR_CODE;
    end
    else
    begin
      state <= next_state;
      lad_oe <= next_oe;
      lad_out <= next_lad;
    end
  end

  // field capture and counters
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      kind <= KIND_IO_RD;
      addr <= 16'h0000;
      wdata <= 8'h00;
      ncnt <= 2'h0;
      wcnt <= 3'h0;
    end
    else
    begin
      if (state == ST_CTYPE)
        kind <= ct_kind;
      if (state == ST_ADDR)
        addr <= addr_shift;
      if (state == ST_WDATA)
        wdata <= {lad_in, wdata[7:4]};
      ncnt <= next_state == state ? 2'(ncnt + 2'h1) : 2'h0;
      wcnt <= state != ST_SYNC ? 3'h0 :
              wcnt == WAIT_SAT ? wcnt : 3'(wcnt + 3'h1);
    end
  end

  // request toggle towards the function side
  always_ff @(posedge link_clk)
  begin
    if (!core_rst_s)
    begin
      req_tgl <= 1'b0;
      issued <= 1'b0;
      usr_req_kind <= KIND_IO_RD;
      usr_req_addr <= 16'h0000;
      usr_req_wdata <= 8'h00;
    end
    else if (state == ST_CTYPE)
      issued <= 1'b0;
    else if (issue && link_rst_n)
    begin
      req_tgl <= ~req_tgl;
      issued <= 1'b1;
      usr_req_kind <= kind;
      usr_req_addr <= addr;
      usr_req_wdata <= wdata;
    end
  end

  // dma request serialiser: start, channel msb first, active
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      ldrq_out <= 1'b1;
      drq_bits <= 5'h1F;
      drq_cnt <= 3'h0;
      drq_last <= 1'b0;
    end
    else if (drq_cnt != 3'h0)
    begin
      ldrq_out <= drq_bits[4];
      drq_bits <= {drq_bits[3:0], 1'b1};
      drq_cnt <= 3'(drq_cnt - 3'h1);
    end
    else
    begin
      ldrq_out <= 1'b1;
      if (dma_act_s != drq_last)
      begin
        drq_bits <= {1'b0, DMA_CHAN, dma_act_s};
        drq_cnt <= LDRQ_BITS;
        drq_last <= dma_act_s;
      end
    end
  end

  // request pin floats while powerdown is seen
  always_ff @(posedge link_clk)
  begin
    ldrq_oe <= pd_s;
    link_up_l <= link_rst_n;
  end

  // function side: present request, capture answer, toggle back
  assign usr_req_valid = req_s ^ req_seen;
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      rd_hold <= 8'h00;
      err_hold <= 1'b0;
    end
    else if (usr_req_valid && usr_req_ready)
    begin
      req_seen <= req_s;
      ack_tgl <= ~ack_tgl;
      rd_hold <= usr_rsp_rdata;
      err_hold <= usr_rsp_err;
    end
  end

  // checks on the link side
  frame_release_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    !lframe_n |=> !lad_oe)
    else $error("lad still driven after frame low");
  bad_type_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == ST_CTYPE && lframe_n && !ct_ok |=> state == ST_IDLE && !lad_oe)
    else $error("unsupported cycle type not ignored");
  io_claim_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == ST_ADDR && ncnt == 2'h3 && !addr_hit && lframe_n
    |=> state == ST_IDLE)
    else $error("i/o cycle claimed outside ranges");
  sync_prompt_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == ST_TAR2 && lframe_n
    |=> lad_oe && (lad_out == SYNC_SHORT || lad_out == SYNC_LONG))
    else $error("no wait sync after turnaround");
  dma_wait_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == ST_SYNC && is_dma |-> lad_oe && lad_out == SYNC_SHORT)
    else $error("dma wait not short code");
  io_wait_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == ST_SYNC && !is_dma |-> lad_oe && lad_out == SYNC_LONG)
    else $error("i/o wait not long code");
  io_rd_waits_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == ST_TAR2 && kind == KIND_IO_RD && lframe_n ##1 lframe_n [*3]
    |-> $past(state == ST_SYNC, 2) && $past(state == ST_SYNC) &&
        state == ST_SYNC)
    else $error("i/o read has fewer than three waits");
  dma_wr_waits_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == ST_TAR2 && kind == KIND_DMA_WR && lframe_n ##1 lframe_n [*4]
    |-> $past(state == ST_SYNC, 3) && $past(state == ST_SYNC, 2) &&
        $past(state == ST_SYNC) && state == ST_SYNC)
    else $error("dma write has fewer than four waits");
  ready_data_a: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == ST_READY && !host_sends && lframe_n
    |=> state == ST_RDATA && lad_oe && lad_out == $past(rd_hold[3:0]))
    else $error("data does not follow ready sync");
  ldrq_float_a: assert property (
    @(posedge link_clk)
    $changed(pd_s) |=> ldrq_oe == $past(pd_s))
    else $error("request pin enable does not track powerdown");
  ldrq_idle_a: assert property (
    @(posedge link_clk)
    !link_rst_n |=> ldrq_out)
    else $error("request pin not high in reset");
endmodule : lpct_target
`default_nettype wire

/* bench/lpct_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// host end of the link: frames cycles, reads back sync and data
module lpct_host_model (
  // link clock
  input wire logic link_clk,
  // resolved bus and device enable
  input wire logic [3:0] lad_bus,
  input wire logic dev_oe,
  // host drive
  output logic lframe_n,
  output logic [3:0] host_lad,
  output logic host_oe
);
  import lpct_pkg::*;
  initial
  begin
    lframe_n = 1'h1;
    host_lad = 4'hF;
    host_oe = 1'h0;
  end
  // one nibble per clock, changed at the falling edge
  task automatic put(input logic fr, input logic [3:0] v);
    @(negedge link_clk);
    lframe_n = fr;
    host_lad = v;
    host_oe = 1'h1;
  endtask : put
  // one whole cycle; abort cuts it at the first wait code
  task automatic cycle(input logic [3:0] ct, input logic [15:0] ad,
      input logic [7:0] wd, input bit abort, output logic [7:0] rd,
      output logic [3:0] sync, output logic [3:0] wcode,
      output int waits, output int first, output logic oe_late);
    logic [3:0] v;
    sync = 4'hF;
    wcode = 4'hF;
    waits = 0;
    first = -1;
    rd = 8'h00;
    oe_late = 1'h0;
    put(1'h0, START_CODE);
    put(1'h1, ct);
    if (ct[3])
    begin
      put(1'h1, ad[3:0]);
      put(1'h1, 4'h0); // single byte only
    end
    else
      for (int i = 3; i >= 0; i--)
        put(1'h1, ad[i*4 +: 4]);
    if (ct == CT_IO_WR || ct == CT_DMA_RD)
    begin
      put(1'h1, wd[3:0]);
      put(1'h1, wd[7:4]);
    end
    put(1'h1, TAR_CODE);
    put(1'h1, TAR_CODE);
    @(negedge link_clk);
    host_oe = 1'h0;
    // watch the sync slot from its first clock on
    // this target syncs writes as well
    for (int i = 0; i < 60; i++)
    begin
      if (i > 0)
        @(negedge link_clk);
      v = lad_bus;
      if (v == SYNC_SHORT || v == SYNC_LONG)
      begin
        if (first < 0)
          first = i;
        wcode = (waits > 0 && wcode != v) ? 4'hE : v;
        waits++;
        if (abort)
          break;
      end
      else if (v == SYNC_READY || v == SYNC_ERR)
      begin
        if (first < 0)
          first = i;
        sync = v;
        break;
      end
      else if (i == 2 && first < 0)
        break; // three clocks without sync
    end
    if (sync != 4'hF && (ct == CT_IO_RD || ct == CT_DMA_WR))
    begin
      @(negedge link_clk);
      rd[3:0] = lad_bus;
      @(negedge link_clk);
      rd[7:4] = lad_bus;
    end
    // abort frame when neither a ready nor an error sync came
    if (sync == 4'hF)
      for (int k = 0; k < 4; k++)
      begin
        put(1'h0, 4'hF);
        if (k == 1)
          oe_late = dev_oe;
      end
    @(negedge link_clk);
    lframe_n = 1'h1;
    host_oe = 1'h0;
    repeat (3) @(negedge link_clk);
  endtask : cycle
endmodule : lpct_host_model
`default_nettype wire

/* bench/lpc_target_interface_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) \
    begin \
      errors++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module lpc_target_interface_tb_top;
  import lpct_pkg::*;
  logic sys_clk, reset_n, link_clk, host_bus_reset_n, lpcpd_n, lframe_n;
  logic [3:0] lad_out, host_lad;
  logic lad_oe, ldrq_out, ldrq_oe, host_oe, usr_req_valid, usr_req_ready;
  lpct_kind_t usr_req_kind, cap_kind;
  logic [15:0] usr_req_addr, cap_addr;
  logic [7:0] usr_req_wdata, usr_rsp_rdata, cap_wdata;
  logic usr_rsp_err, usr_dma_active, usr_link_up;
  logic [1:0] usr_range_en;
  int errors, samples_checked, cap_n;
  // pulled-up bus
  wire logic [3:0] lad_in = lad_oe ? lad_out : host_oe ? host_lad : 4'hF;
  lpct_target u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .link_clk(link_clk), .host_bus_reset_n(host_bus_reset_n),
    .lpcpd_n(lpcpd_n), .lframe_n(lframe_n), .lad_in(lad_in),
    .lad_out(lad_out), .lad_oe(lad_oe), .ldrq_out(ldrq_out),
    .ldrq_oe(ldrq_oe), .usr_req_valid(usr_req_valid),
    .usr_req_ready(usr_req_ready), .usr_req_kind(usr_req_kind),
    .usr_req_addr(usr_req_addr), .usr_req_wdata(usr_req_wdata),
    .usr_rsp_rdata(usr_rsp_rdata), .usr_rsp_err(usr_rsp_err),
    .usr_range_en(usr_range_en), .usr_dma_active(usr_dma_active),
    .usr_link_up(usr_link_up));
  lpct_host_model u_host (.link_clk(link_clk), .lad_bus(lad_in),
    .dev_oe(lad_oe), .lframe_n(lframe_n), .host_lad(host_lad),
    .host_oe(host_oe));
  // clocks, link unrelated in phase
  initial
  begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk = 1'h0;
    #1;
    forever
    begin
      #7 link_clk = 1'h1;
      #8 link_clk = 1'h0;
    end
  end
  // function answers each request at once and logs it
  always @(negedge sys_clk)
    usr_req_ready <= (usr_req_valid === 1'h1);
  always @(posedge sys_clk)
    if (usr_req_valid && usr_req_ready)
    begin
      cap_kind <= usr_req_kind;
      cap_addr <= usr_req_addr;
      cap_wdata <= usr_req_wdata;
      cap_n <= cap_n + 1;
    end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  // one claimed transfer, judged in full
  task automatic xfer(input logic [3:0] ct, input logic [15:0] ad,
      input logic [7:0] dt, input logic err, input logic [3:0] code,
      input int nw, input lpct_kind_t kd);
    logic [7:0] rd;
    logic [3:0] sy, wc;
    int nwt, fst, n0;
    logic ol;
    @(negedge sys_clk);
    n0 = cap_n;
    usr_rsp_rdata = dt;
    usr_rsp_err = err;
    u_host.cycle(ct, ad, dt, 1'h0, rd, sy, wc, nwt, fst, ol);
    `CHK("sync", err ? SYNC_ERR : SYNC_READY, sy)
    `CHK("wait code", code, wc)
    `CHK("enough waits", 1'h1, nwt >= nw)
    `CHK("sync slot", 1'h1, fst < 3)
    `CHK("requests", n0 + 1, cap_n)
    `CHK("kind", kd, cap_kind)
    if (!ct[3])
      `CHK("addr", ad, cap_addr)
    if (ct == CT_IO_WR || ct == CT_DMA_RD)
      `CHK("wdata", dt, cap_wdata)
    else
      `CHK("rdata", dt, rd)
  endtask : xfer
  task automatic t_io();
    xfer(CT_IO_WR, 16'h0300, 8'hC3, 1'h0, SYNC_LONG, 2, KIND_IO_WR);
    xfer(CT_IO_RD, 16'h0317, 8'h5A, 1'h0, SYNC_LONG, 3, KIND_IO_RD);
    $display("test io done");
  endtask : t_io
  task automatic t_dma();
    xfer(CT_DMA_RD, 16'h0002, 8'h96, 1'h0, SYNC_SHORT, 3, KIND_DMA_RD);
    xfer(CT_DMA_WR, 16'h0002, 8'h3C, 1'h0, SYNC_SHORT, 4, KIND_DMA_WR);
    $display("test dma done");
  endtask : t_dma
  task automatic t_err();
    xfer(CT_IO_RD, 16'h0310, 8'hA5, 1'h1, SYNC_LONG, 3, KIND_IO_RD);
    xfer(CT_DMA_WR, 16'h0002, 8'h69, 1'h1, SYNC_SHORT, 4, KIND_DMA_WR);
    $display("test error done");
  endtask : t_err
  // cycles the device must leave alone
  task automatic t_refuse();
    logic [3:0] cts [4] = '{CT_IO_RD, 4'h4, CT_DMA_RD, CT_IO_WR};
    logic [15:0] ads [4] = '{16'h0308, 16'h0310, 16'h0003, 16'h0300};
    logic [7:0] rd;
    logic [3:0] sy, wc;
    int nwt, fst, n0;
    logic ol;
    usr_range_en = 2'h2;
    for (int i = 0; i < 4; i++)
    begin
      n0 = cap_n;
      u_host.cycle(cts[i], ads[i], 8'h11, 1'h0, rd, sy, wc, nwt, fst, ol);
      `CHK("ignored drive", -1, fst)
      `CHK("ignored request", n0, cap_n)
    end
    usr_range_en = 2'h3;
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_abort();
    logic [7:0] rd;
    logic [3:0] sy, wc;
    int nwt, fst;
    logic ol;
    u_host.cycle(CT_IO_RD, 16'h0301, 8'h00, 1'h1, rd, sy, wc, nwt, fst, ol);
    `CHK("released", 1'h0, ol)
    xfer(CT_IO_WR, 16'h0302, 8'h7E, 1'h0, SYNC_LONG, 2, KIND_IO_WR);
    $display("test abort done");
  endtask : t_abort
  // each change of the active level sends one request message
  task automatic t_dmareq();
    logic [4:0] bits;
    for (int a = 1; a >= 0; a--)
    begin
      @(negedge sys_clk);
      usr_dma_active = a[0];
      for (int k = 0; k < 30 && ldrq_out !== 1'h0; k++)
        @(negedge link_clk);
      if (ldrq_out !== 1'h0)
      begin
        errors++;
        summarize();
      end
      for (int k = 0; k < 5; k++)
      begin
        @(negedge link_clk);
        bits = {bits[3:0], ldrq_out};
      end
      `CHK("ldrq message", {3'h2, a[0], 1'h1}, bits)
    end
    $display("test dma request done");
  endtask : t_dmareq
  // powerdown then bus reset, each without the other
  task automatic t_power();
    logic [7:0] rd;
    logic [3:0] sy, wc;
    int nwt, fst;
    logic ol;
    for (int w = 0; w < 2; w++)
    begin
      @(negedge sys_clk);
      lpcpd_n = w[0]; // link clock keeps running
      host_bus_reset_n = !w[0];
      u_host.cycle(CT_IO_RD, 16'h0300, 8'h00, 1'h0, rd, sy, wc, nwt, fst, ol);
      `CHK("drive in reset", -1, fst)
      `CHK("ldrq level", 1'h1, ldrq_out)
      `CHK("ldrq enable", w[0], ldrq_oe)
      `CHK("link up", 1'h0, usr_link_up)
      lpcpd_n = 1'h1;
      host_bus_reset_n = 1'h1;
      repeat (8) @(negedge link_clk);
      `CHK("ldrq driven", 2'h3, {ldrq_oe, ldrq_out})
      `CHK("link back", 1'h1, usr_link_up)
      xfer(CT_IO_WR, 16'h0305, 8'h5C, 1'h0, SYNC_LONG, 2, KIND_IO_WR);
    end
    $display("test power done");
  endtask : t_power
  initial
  begin
    errors = 0;
    samples_checked = 0;
    cap_n = 0;
    reset_n = 1'h0;
    host_bus_reset_n = 1'h0;
    lpcpd_n = 1'h1;
    usr_req_ready = 1'h0;
    usr_rsp_rdata = 8'h00;
    usr_rsp_err = 1'h0;
    usr_range_en = 2'h3;
    usr_dma_active = 1'h0;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'h1;
    repeat (6) @(negedge link_clk);
    host_bus_reset_n = 1'h1;
    repeat (6) @(negedge link_clk);
    t_io();
    t_dma();
    t_err();
    t_refuse();
    t_abort();
    t_dmareq();
    t_power();
    summarize();
  end
  // cut a hang short
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
endmodule : lpc_target_interface_tb_top
`default_nettype wire
